// ===== design/memory_map_defs.svh
`ifndef MEMORY_MAP_DEFS_SVH
`define MEMORY_MAP_DEFS_SVH

// Core register file addresses, decoded in either bank
`define FA_INDIRECT_WINDOW      7'h00
`define FA_PC_LOW_BYTE          7'h02
`define FA_CORE_STATUS          7'h03
`define FA_FILE_SELECT          7'h04
`define FA_PC_HIGH_LATCH        7'h0A
`define FA_INTERRUPT_CONTROL    7'h0B

// Upper nibble of the bank 1 window onto the top of bank 0 RAM
`define GPR_MIRROR_NIBBLE       3'h7

// Reset values
`define CORE_STATUS_RESET       8'h18
`define FILE_SELECT_RESET       8'h00
`define PC_HIGH_LATCH_RESET     5'h00
`define INTERRUPT_CONTROL_RESET 8'h00

// Software-writable status bits; the time-out and power-down bits are not
`define CORE_STATUS_WR_MASK     8'hE7

// Program counter vectors
`define RESET_VECTOR            13'h0000
`define INT_VECTOR              13'h0004

// Storage geometry
`define PROG_AWIDTH             10
`define PROG_DWIDTH             14
`define GPR_AWIDTH              6
`define GPR_DWIDTH              8

`endif

// ===== design/memory_map_pkg.sv
`default_nettype none

package memory_map_pkg;

    typedef logic [12:0] pc_t;
    typedef logic [13:0] prog_word_t;
    typedef logic [7:0]  data_addr_t;
    typedef logic [6:0]  file_addr_t;

    typedef struct packed {
        logic indirect_page_bit;
        logic upper_bank_bit;
        logic bank_select_bit;
        logic time_out;
        logic power_down;
        logic zero;
        logic digit_carry;
        logic carry;
    } core_status_t;

    typedef enum logic [1:0] {
        SRC_ZERO = 2'b00,
        SRC_CORE = 2'b01,
        SRC_GPR  = 2'b10
    } read_source_t;

endpackage // memory_map_pkg

`default_nettype wire

// ===== design/pc_if.sv
`default_nettype none

interface pc_if;
    logic                   inc;
    logic                   int_take;
    logic                   jump;
    logic [10:0]            jump_addr;
    logic                   pcl_wr;
    logic [7:0]             pcl_data;
    logic [4:0]             program_counter_high_latch;
    memory_map_pkg::pc_t    pc;

    modport ctrl (
        output inc, int_take, jump, jump_addr, pcl_wr, pcl_data, program_counter_high_latch,
        input  pc
    );

    modport unit (
        input  inc, int_take, jump, jump_addr, pcl_wr, pcl_data, program_counter_high_latch,
        output pc
    );
endinterface // pc_if

`default_nettype wire

// ===== design/sync_ram.sv
`default_nettype none

module sync_ram #(
    parameter int unsigned AW = 6,
    parameter int unsigned DW = 8
) (
    input  wire logic          mclk_i,
    input  wire logic          rstn_i,
    input  wire logic          we_i,
    input  wire logic [AW-1:0] waddr_i,
    input  wire logic [DW-1:0] wdata_i,
    input  wire logic [AW-1:0] raddr_i,
    output logic      [DW-1:0] rdata_o
);
    localparam int unsigned DEPTH = 2 ** AW;

    // Plain static cells: no reset, no refresh
    logic [DW-1:0] mem [DEPTH];

    always_ff @(posedge mclk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_o <= '0;
        end else begin
            rdata_o <= mem[raddr_i];
        end
    end
endmodule // sync_ram

`default_nettype wire

// ===== design/program_counter.sv
`include "memory_map_defs.svh"
`default_nettype none

module program_counter (
    input  wire logic mclk_i,
    input  wire logic rstn_i,
    pc_if.unit        pcb
);
    memory_map_pkg::pc_t pc_reg;
    memory_map_pkg::pc_t pc_next;
    memory_map_pkg::pc_t pc_plus;
    memory_map_pkg::pc_t pcl_target;
    memory_map_pkg::pc_t jump_target;
    logic                ran_reg;

    assign pc_plus     = pc_reg + 13'h0001;
    assign pcl_target  = {pcb.program_counter_high_latch, pcb.pcl_data};
    assign jump_target = {pcb.program_counter_high_latch[4:3], pcb.jump_addr};

    // Interrupt entry outranks a software write, which outranks a jump
    assign pc_next = pcb.int_take ? `INT_VECTOR :
                     pcb.pcl_wr   ? pcl_target  :
                     pcb.jump     ? jump_target :
                     pcb.inc      ? pc_plus     : pc_reg;

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pc_reg  <= `RESET_VECTOR;
            ran_reg <= 1'b0;
        end else begin
            pc_reg  <= pc_next;
            ran_reg <= 1'b1;
        end
    end

    assign pcb.pc = pc_reg;

    a_reset_start: assert property (
        @(posedge mclk_i) disable iff (!rstn_i)
        !ran_reg |-> pc_reg == `RESET_VECTOR)
        else $error("fetch did not start at the reset vector");

    a_int_vector: assert property (
        @(posedge mclk_i) disable iff (!rstn_i)
        pcb.int_take |=> pc_reg == `INT_VECTOR)
        else $error("interrupt did not load the interrupt vector");

    a_pc_count_wrap: assert property (
        @(posedge mclk_i) disable iff (!rstn_i)
        pcb.inc && !pcb.int_take && !pcb.pcl_wr && !pcb.jump
        |=> pc_reg == $past(pc_reg) + 13'h0001)
        else $error("program counter did not step by one in 13 bits");
endmodule // program_counter

`default_nettype wire

// ===== design/program_data_memory_map.sv
// How it works
// - 13-bit program counter, 8K x 14 space
// - Only words 0000h-03FFh are real storage
// - Higher program addresses wrap into 1K
// - Reset starts fetching at 0000h
// - Taken interrupt loads counter with 0004h
// - Data space is two banks
// - Lowest 32 locations per bank are registers
// - Bank 0 40h-7Fh is general RAM
// - Bank 1 F0h-FFh reach bank 0 70h-7Fh
// - Unimplemented locations read zero, ignore writes
// - Bank select bit picks bank directly
// - General RAM is 64 by 8 bits
// - RAM reachable directly or through pointer
// - Special registers hold value without refresh
`include "memory_map_defs.svh"
`default_nettype none

module program_data_memory_map (
    input  wire logic        mclk_i,
    input  wire logic        rstn_i,
    input  wire logic [6:0]  reg_addr_i,
    input  wire logic [7:0]  reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic      [7:0]  reg_rdata_o,
    input  wire logic        alu_flags_we_i,
    input  wire logic [2:0]  alu_flags_i,
    input  wire logic        pc_inc_i,
    input  wire logic        int_take_i,
    input  wire logic        jump_i,
    input  wire logic [10:0] jump_addr_i,
    input  wire logic        prog_wr_i,
    input  wire logic [12:0] prog_addr_i,
    input  wire logic [13:0] prog_wdata_i,
    output logic      [12:0] pc_o,
    output logic      [13:0] instr_o,
    output logic      [7:0]  interrupt_control_o
);

    memory_map_pkg::core_status_t status_reg;
    memory_map_pkg::core_status_t status_next;
    memory_map_pkg::read_source_t src_reg;
    memory_map_pkg::read_source_t src_next;
    memory_map_pkg::data_addr_t   eff_addr;
    memory_map_pkg::file_addr_t   low_addr;

    logic [7:0] fsr_reg;
    logic [7:0] fsr_next;
    logic [4:0] program_counter_high_latch_reg;
    logic [4:0] program_counter_high_latch_next;
    logic [7:0] interrupt_control_reg;
    logic [7:0] interrupt_control_next;
    logic [7:0] core_rdata_reg;
    logic [7:0] core_rdata;
    logic [7:0] status_sw;
    logic [7:0] status_wr_val;
    logic [7:0] gpr_rdata;
    logic [5:0] gpr_idx;
    logic       indirect;
    logic       bank;
    logic       access;
    logic       sfr_area;
    logic       hit_pcl;
    logic       hit_status;
    logic       hit_fsr;
    logic       hit_latch;
    logic       hit_interrupt_control;
    logic       core_hit;
    logic       gpr_hit;
    logic       gpr_we;

    pc_if pcb ();

    // Address formation: the window location swaps in the full pointer
    assign indirect = reg_addr_i == `FA_INDIRECT_WINDOW;
    // Reserved page bit plays no part in decode
    assign eff_addr = indirect ? fsr_reg :
                      {status_reg.bank_select_bit, reg_addr_i};
    assign low_addr = eff_addr[6:0];
    assign bank     = eff_addr[7];
    assign access   = reg_wr_i | reg_rd_i;

    // Core registers decode on the low seven bits only
    assign hit_pcl    = low_addr == `FA_PC_LOW_BYTE;
    assign hit_status = low_addr == `FA_CORE_STATUS;
    assign hit_fsr    = low_addr == `FA_FILE_SELECT;
    assign hit_latch  = low_addr == `FA_PC_HIGH_LATCH;
    assign hit_interrupt_control = low_addr == `FA_INTERRUPT_CONTROL;
    assign core_hit   = hit_pcl | hit_status | hit_fsr |
                        hit_latch | hit_interrupt_control;

    // Lowest 32 of each bank are registers, never RAM
    assign sfr_area = low_addr[6:5] == 2'b00;

    // Bank 0 upper half is RAM; bank 1 only its top 16 alias onto it
    assign gpr_hit = bank ? (low_addr[6:4] == `GPR_MIRROR_NIBBLE)
                          : low_addr[6];
    assign gpr_idx = low_addr[5:0];
    assign gpr_we  = reg_wr_i & gpr_hit;

    sync_ram #(
        .AW (`GPR_AWIDTH),
        .DW (`GPR_DWIDTH)
    ) gpr_store (
        .mclk_i  (mclk_i),
        .rstn_i  (rstn_i),
        .we_i    (gpr_we),
        .waddr_i (gpr_idx),
        .wdata_i (reg_wdata_i),
        .raddr_i (gpr_idx),
        .rdata_o (gpr_rdata)
    );

    // Core register read selection
    assign core_rdata = hit_pcl    ? pcb.pc[7:0]         :
                        hit_status ? status_reg          :
                        hit_fsr    ? fsr_reg             :
                        hit_latch  ? {3'h0, program_counter_high_latch_reg}  :
                        hit_interrupt_control ? interrupt_control_reg          : 8'h00;

    // Locations that decode to nothing read zero
    assign src_next = !reg_rd_i ? memory_map_pkg::SRC_ZERO :
                      core_hit  ? memory_map_pkg::SRC_CORE :
                      gpr_hit   ? memory_map_pkg::SRC_GPR  :
                                  memory_map_pkg::SRC_ZERO;

    // Status: software write first, core flag update wins the low bits
    assign status_sw     = (status_reg & ~`CORE_STATUS_WR_MASK) |
                           (reg_wdata_i & `CORE_STATUS_WR_MASK);
    assign status_wr_val = (reg_wr_i && hit_status) ? status_sw
                                                    : status_reg;
    assign status_next   = alu_flags_we_i
                         ? {status_wr_val[7:3], alu_flags_i}
                         : status_wr_val;

    assign fsr_next    = (reg_wr_i && hit_fsr) ? reg_wdata_i : fsr_reg;
    assign program_counter_high_latch_next = (reg_wr_i && hit_latch) ? reg_wdata_i[4:0]
                                                 : program_counter_high_latch_reg;
    assign interrupt_control_next = (reg_wr_i && hit_interrupt_control) ? reg_wdata_i
                                                  : interrupt_control_reg;

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            status_reg <= `CORE_STATUS_RESET;
            fsr_reg    <= `FILE_SELECT_RESET;
            program_counter_high_latch_reg <= `PC_HIGH_LATCH_RESET;
            interrupt_control_reg <= `INTERRUPT_CONTROL_RESET;
        end else begin
            status_reg <= status_next;
            fsr_reg    <= fsr_next;
            program_counter_high_latch_reg <= program_counter_high_latch_next;
            interrupt_control_reg <= interrupt_control_next;
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            src_reg        <= memory_map_pkg::SRC_ZERO;
            core_rdata_reg <= 8'h00;
        end else begin
            src_reg        <= src_next;
            core_rdata_reg <= core_rdata;
        end
    end

    // Both candidates are registered; only the select is applied late
    assign reg_rdata_o =
        (src_reg == memory_map_pkg::SRC_CORE) ? core_rdata_reg :
        (src_reg == memory_map_pkg::SRC_GPR)  ? gpr_rdata      : 8'h00;

    assign interrupt_control_o = interrupt_control_reg;

    // Program counter control
    assign pcb.inc       = pc_inc_i;
    assign pcb.int_take  = int_take_i;
    assign pcb.jump      = jump_i;
    assign pcb.jump_addr = jump_addr_i;
    assign pcb.pcl_wr    = reg_wr_i & hit_pcl;
    assign pcb.pcl_data  = reg_wdata_i;
    assign pcb.program_counter_high_latch    = program_counter_high_latch_reg;

    program_counter pc_unit (
        .mclk_i (mclk_i),
        .rstn_i (rstn_i),
        .pcb    (pcb)
    );

    assign pc_o = pcb.pc;

    // Program store: only the low ten address bits reach the cells
    sync_ram #(
        .AW (`PROG_AWIDTH),
        .DW (`PROG_DWIDTH)
    ) prog_store (
        .mclk_i  (mclk_i),
        .rstn_i  (rstn_i),
        .we_i    (prog_wr_i),
        .waddr_i (prog_addr_i[9:0]),
        .wdata_i (prog_wdata_i),
        .raddr_i (pcb.pc[9:0]),
        .rdata_o (instr_o)
    );

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rstn_i);

    sequence s_prog_write;
        prog_wr_i;
    endsequence

    sequence s_fetch_same;
        !prog_wr_i && pc_o[9:0] == $past(prog_addr_i[9:0]);
    endsequence

    sequence s_gpr_write;
        reg_wr_i && gpr_hit;
    endsequence

    sequence s_gpr_read_same;
        reg_rd_i && gpr_hit && gpr_idx == $past(gpr_idx);
    endsequence

    sequence s_mirror_write;
        reg_wr_i && eff_addr[7:4] == 4'hF;
    endsequence

    sequence s_bank0_top_read;
        reg_rd_i && eff_addr[7:4] == 4'h7 &&
        eff_addr[3:0] == $past(eff_addr[3:0]);
    endsequence

    a_prog_wrap: assert property (
        s_prog_write ##1 s_fetch_same |=>
        instr_o == $past(prog_wdata_i, 2))
        else $error("fetch did not return word written at wrapped address");

    a_gpr_readback: assert property (
        s_gpr_write ##1 s_gpr_read_same |=>
        reg_rdata_o == $past(reg_wdata_i, 2))
        else $error("general RAM did not return the written byte");

    a_mirror_alias: assert property (
        s_mirror_write ##1 s_bank0_top_read |=>
        reg_rdata_o == $past(reg_wdata_i, 2))
        else $error("bank 1 top did not alias bank 0 top");

    a_unimpl_zero: assert property (
        reg_rd_i && !core_hit && !gpr_hit |=> reg_rdata_o == 8'h00)
        else $error("unimplemented location did not read zero");

    a_unimpl_nowrite: assert property (
        reg_wr_i && !core_hit && !gpr_hit && !alu_flags_we_i |=>
        $stable(fsr_reg) && $stable(interrupt_control_reg) && $stable(status_reg))
        else $error("write to unimplemented location changed state");

    a_sfr_region: assert property (
        access && sfr_area |-> !gpr_hit && !gpr_we)
        else $error("register area decoded as general RAM");

    a_bank_select: assert property (
        reg_wr_i && !indirect && reg_addr_i[6] |->
        gpr_we == (!status_reg.bank_select_bit ||
                   reg_addr_i[6:4] == `GPR_MIRROR_NIBBLE))
        else $error("bank select bit did not steer a direct write");

    a_core_mirror: assert property (
        reg_rd_i && !indirect && reg_addr_i == `FA_FILE_SELECT |=>
        reg_rdata_o == $past(fsr_reg))
        else $error("pointer register not seen alike in both banks");

    a_indirect_read: assert property (
        reg_rd_i && indirect && fsr_reg[6:0] == `FA_PC_HIGH_LATCH |=>
        reg_rdata_o == {3'h0, $past(program_counter_high_latch_reg)})
        else $error("indirect read did not follow the pointer");

    a_pcl_read: assert property (
        reg_rd_i && hit_pcl |=> reg_rdata_o == $past(pc_o[7:0]))
        else $error("low byte read did not show the program counter");

    a_status_hold: assert property (
        !reg_wr_i && !alu_flags_we_i |=> $stable(status_reg))
        else $error("status changed without a write");

endmodule // program_data_memory_map

`default_nettype wire

// ===== tb/cpu_core_model.sv
`default_nettype none

module cpu_core_model (
    input  wire logic        mclk_i,
    output logic      [6:0]  reg_addr_o,
    output logic      [7:0]  reg_wdata_o,
    output logic             reg_wr_o,
    output logic             reg_rd_o,
    output logic             flags_we_o,
    output logic      [2:0]  flags_o,
    output logic             pc_inc_o,
    output logic             int_take_o,
    output logic             jump_o,
    output logic      [10:0] jump_addr_o,
    output logic             prog_wr_o,
    output logic      [12:0] prog_addr_o,
    output logic      [13:0] prog_wdata_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        {reg_addr_o, reg_wdata_o, reg_wr_o, reg_rd_o, flags_we_o} = '0;
        {flags_o, pc_inc_o, int_take_o, jump_o, jump_addr_o} = '0;
        {prog_wr_o, prog_addr_o, prog_wdata_o} = '0;
    end

    // One cycle; s = {prog_wr, flags_we, jump, int_take, inc, rd, wr}
    task automatic cyc(input logic [6:0] s, input logic [12:0] a,
                       input logic [13:0] d);
        logic [7:0] wd;
        wd = d[7:0];
        if (a[6:0] == 7'h03) begin
            wd[7:6] = 2'b00; // Reserved status bits kept clear
        end
        @(posedge mclk_i);
        reg_wr_o     <= s[0];
        reg_rd_o     <= s[1];
        pc_inc_o     <= s[2];
        int_take_o   <= s[3];
        jump_o       <= s[4];
        flags_we_o   <= s[5];
        prog_wr_o    <= s[6];
        reg_addr_o   <= a[6:0];
        reg_wdata_o  <= wd;
        flags_o      <= d[2:0];
        jump_addr_o  <= a[10:0];
        prog_addr_o  <= a;
        prog_wdata_o <= d;
    endtask
endmodule // cpu_core_model

`default_nettype wire

// ===== tb/program_data_memory_map_tb.sv
`default_nettype none

module program_data_memory_map_tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [6:0] WR = 7'h01;
    localparam logic [6:0] RD = 7'h02;
    localparam logic [6:0] INC = 7'h04;
    localparam logic [6:0] ITK = 7'h08;
    localparam logic [6:0] JMP = 7'h10;
    localparam logic [6:0] FLG = 7'h20;
    localparam logic [6:0] PWR = 7'h40;

    logic        mclk_i = 1'b0;
    logic        rstn_i = 1'b0;
    logic [6:0]  addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
    logic        fwe;
    logic [2:0]  flags;
    logic        inc;
    logic        itk;
    logic        jmp;
    logic [10:0] jaddr;
    logic        pwr;
    logic [12:0] paddr;
    logic [13:0] pdata;
    logic [7:0]  rdata;
    logic [12:0] pc;
    logic [13:0] instr;
    logic [7:0]  ictl;
    logic [7:0]  exp_q[$];
    logic        rd_seen = 1'b0;
    logic [6:0]  ram_a[5] = '{7'h40, 7'h5B, 7'h6F, 7'h70, 7'h7F};
    logic [7:0]  ram_v[5];
    logic [31:0] seed = 32'h041EF78D;
    int          n_fail = 0;
    int          checked = 0;

    always #25ns mclk_i = ~mclk_i;

    cpu_core_model core (.mclk_i(mclk_i), .reg_addr_o(addr),
        .reg_wdata_o(wdata), .reg_wr_o(wr), .reg_rd_o(rd),
        .flags_we_o(fwe), .flags_o(flags), .pc_inc_o(inc),
        .int_take_o(itk), .jump_o(jmp), .jump_addr_o(jaddr),
        .prog_wr_o(pwr), .prog_addr_o(paddr), .prog_wdata_o(pdata));

    program_data_memory_map uut (.mclk_i(mclk_i), .rstn_i(rstn_i),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_rdata_o(rdata), .alu_flags_we_i(fwe),
        .alu_flags_i(flags), .pc_inc_i(inc), .int_take_i(itk),
        .jump_i(jmp), .jump_addr_i(jaddr), .prog_wr_i(pwr),
        .prog_addr_i(paddr), .prog_wdata_i(pdata), .pc_o(pc),
        .instr_o(instr), .interrupt_control_o(ictl));

    function automatic logic [31:0] xorshift(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction

    task automatic chk(input string name, input logic [13:0] exp,
                       input logic [13:0] got);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic summarize();
        if (n_fail == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Read data stands only in the cycle after the strobe, zero elsewhere
    always @(posedge mclk_i) rd_seen <= rd;
    always @(negedge mclk_i) begin
        if (rd_seen) begin
            chk("reg_rdata_o", {6'h00, exp_q.pop_front()}, {6'h00, rdata});
        end else if (rstn_i) begin
            chk("reg_rdata_o idle", 14'h0000, {6'h00, rdata});
        end
    end

    task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
        core.cyc(WR, {6'h00, a}, {6'h00, d});
    endtask

    task automatic rd_reg(input logic [6:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        core.cyc(RD, {6'h00, a}, 14'h0000);
    endtask

    task automatic pc_op(input logic [6:0] s, input logic [12:0] a,
                         input logic [13:0] d, input logic [12:0] e);
        core.cyc(s, a, d);
        core.cyc(7'h00, 13'h0000, 14'h0000);
        @(negedge mclk_i);
        chk("pc_o", {1'b0, e}, {1'b0, pc});
    endtask

    task automatic after_reset();
        repeat (3) @(posedge mclk_i);
        rstn_i <= 1'b1;
        @(negedge mclk_i);
        chk("pc_o", 14'h0000, {1'b0, pc});
        chk("interrupt_control_o", 14'h0000, {6'h00, ictl});
        rd_reg(7'h03, 8'h18);
        rd_reg(7'h04, 8'h00);
        rd_reg(7'h0A, 8'h00);
    endtask

    initial begin
        #100us;
        n_fail++;
        summarize();
    end

    initial begin
        after_reset();
        foreach (ram_a[i]) begin
            seed = xorshift(seed);
            ram_v[i] = seed[7:0];
            wr_reg(ram_a[i], seed[7:0]);
        end
        foreach (ram_a[i]) rd_reg(ram_a[i], ram_v[i]);
        wr_reg(7'h03, 8'hE0);
        rd_reg(7'h03, 8'h38);
        rd_reg(7'h7F, ram_v[4]);
        wr_reg(7'h70, 8'hA5);
        wr_reg(7'h40, 8'h3C);
        rd_reg(7'h40, 8'h00);
        rd_reg(7'h20, 8'h00);
        wr_reg(7'h04, 8'h45);
        wr_reg(7'h0B, 8'h81);
        wr_reg(7'h00, 8'h99);
        wr_reg(7'h03, 8'h00);
        rd_reg(7'h04, 8'h45);
        rd_reg(7'h0B, 8'h81);
        rd_reg(7'h45, 8'h99);
        rd_reg(7'h70, 8'hA5);
        rd_reg(7'h40, ram_v[0]);
        rd_reg(7'h01, 8'h00);
        wr_reg(7'h04, 8'hF0);
        rd_reg(7'h00, 8'hA5);
        wr_reg(7'h04, 8'h00);
        rd_reg(7'h00, 8'h00);
        core.cyc(FLG, 13'h0000, 14'h0005);
        rd_reg(7'h03, 8'h1D);
        chk("interrupt_control_o", 14'h0081, {6'h00, ictl});
        core.cyc(PWR, 13'h1405, 14'h2ABC);
        pc_op(ITK | INC, 13'h0000, 14'h0000, 13'h0004);
        pc_op(INC, 13'h0000, 14'h0000, 13'h0005);
        core.cyc(7'h00, 13'h0000, 14'h0000);
        @(negedge mclk_i);
        chk("instr_o", 14'h2ABC, instr);
        core.cyc(PWR, 13'h0405, 14'h1234);
        core.cyc(7'h00, 13'h0000, 14'h0000);
        core.cyc(7'h00, 13'h0000, 14'h0000);
        @(negedge mclk_i);
        chk("instr_o", 14'h1234, instr);
        wr_reg(7'h0A, 8'h1F);
        pc_op(JMP, 13'h07FF, 14'h0000, 13'h1FFF);
        pc_op(INC, 13'h0000, 14'h0000, 13'h0000);
        pc_op(WR, 13'h0002, 14'h0034, 13'h1F34);
        rd_reg(7'h02, 8'h34);
        core.cyc(7'h00, 13'h0000, 14'h0000);
        @(posedge mclk_i);
        rstn_i <= 1'b0;
        after_reset();
        core.cyc(7'h00, 13'h0000, 14'h0000);
        repeat (2) @(posedge mclk_i);
        summarize();
    end
endmodule // program_data_memory_map_tb

`default_nettype wire
